/* File: pkg/rspm_pkg.sv */
package rspm_pkg;
    // interface mode encoding {iface_mode_bit1, iface_mode_bit0}
    localparam logic [1:0] IFACE_I2C = 2'h0;
    localparam logic [1:0] IFACE_SPI_SLAVE = 2'h1;
    localparam logic [1:0] IFACE_SPI_MASTER = 2'h2;
    localparam logic [1:0] IFACE_RESERVED = 2'h3;
    // reset values
    localparam logic [2:0] AUTO_CFG_RST = 3'h0;
    localparam logic [1:0] IFACE_RST = 2'h0;
    localparam logic FTEST_RST = 1'b0;
    localparam logic [3:0] GPIO_LATCH_RST = 4'h0;
    localparam logic [3:0] GPIO_SYNC_RST = 4'h0;
    localparam logic [3:0] GPIO_VAL_RST = 4'h0;
    localparam logic [3:0] GPIO_OE_N_RST = 4'hF;
    localparam logic CS_DRIVE_RST = 1'b0;
    localparam logic CS_VAL_RST = 1'b1;
    // gpio config field layout: bit 1 = output enable, bit 0 = output value
    localparam int CFG_OE_BIT = 1;
    localparam int CFG_VAL_BIT = 0;
    localparam int NUM_GPIO = 4;
    typedef enum logic [1:0] {
        RSPM_ST_CAPTURE,
        RSPM_ST_AUTOCFG,
        RSPM_ST_RUN
    } rspm_state_t;
endpackage

/* File: rtl/rspm_strap_mux.sv */
`timescale 1ns/1ns
// Behaviour
// RULE_01: after reset the three auto-configure pins work as gpio pins 0 to 2.
// RULE_02: gpio 0 and 1 set by config reg 1; gpio 2 by gpio_pin_2_config field.
// RULE_03: each gpio pin reports a real-time and a latched status bit.
// RULE_04: test/gpio_pin_3 is sampled as factory_test_strap at reset release.
// RULE_05: factory test mode entered when that strap is sampled high.
// RULE_06: after reset the test pin is gpio_pin_3, set by gpio_pin_3_config field.
// RULE_07: chip-select pin is sampled as iface_mode_bit0 at reset release.
// RULE_08: as spi slave, an external master drives spi_select_n low.
// RULE_09: as spi master, device drives spi_select_n low during auto-configuration.
// RULE_10: after auto-configuration, spi master stops driving spi_select_n, pin is input.
// RULE_11: while rst_n is low all logic holds default values.
// RULE_12: gpio pins 0 to 2 are sampled as auto_config_select at reset release.
// RULE_13: captured straps stay unchanged until the next reset.
module rspm_strap_mux (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [3:0] gpio_pin_in,
    output logic [3:0] gpio_pin_out,
    output logic [3:0] gpio_pin_oe_n,
    input wire logic spi_select_n_in,
    output logic spi_select_n_out,
    output logic spi_select_n_oe_n,
    input wire logic iface_mode_bit1,
    input wire logic [3:0] gpio_config_reg_1,
    input wire logic [1:0] gpio_pin_2_config,
    input wire logic [1:0] gpio_pin_3_config,
    input wire logic autocfg_busy,
    input wire logic autocfg_done,
    input wire logic latch_clear,
    output logic [2:0] auto_config_select,
    output logic [1:0] iface_mode,
    output logic factory_test_mode,
    output logic straps_valid,
    output logic autocfg_active,
    output logic spi_select_n_slave,
    output logic [3:0] gpio_status_rt,
    output logic [3:0] gpio_status_latched
);

    ////////////////////////////////////////////////////////////////////////////
    rspm_pkg::rspm_state_t state_reg, state_next;
    logic [2:0] acs_reg, acs_next;
    logic [1:0] ifm_reg, ifm_next;
    logic ftest_reg, ftest_next;
    logic [3:0] rt_reg, rt_next;
    logic [3:0] lat_reg, lat_next;
    logic cs_drive_reg, cs_drive_next;
    logic cs_val_reg, cs_val_next;
    logic [3:0] drv_val_reg, drv_val_next;
    logic [3:0] drv_oe_n_reg, drv_oe_n_next;
    logic [1:0] mode_strap;
    logic capture_now;
    logic [1:0] pin_cfg [rspm_pkg::NUM_GPIO];

    assign pin_cfg[0] = gpio_config_reg_1[1:0]; // see RULE_02
    assign pin_cfg[1] = gpio_config_reg_1[3:2]; // see RULE_02
    assign pin_cfg[2] = gpio_pin_2_config; // see RULE_02
    assign pin_cfg[3] = gpio_pin_3_config; // see RULE_06

    // the chip-select pin doubles as the low mode strap until capture
    assign mode_strap = {iface_mode_bit1, spi_select_n_in}; // see RULE_07
    assign capture_now = (state_reg == rspm_pkg::RSPM_ST_CAPTURE);

    ////////////////////////////////////////////////////////////////////////////
    // the first enabled edge after release captures the straps; rst_n itself
    // cannot be a data input under async reset, so this edge stands in for it
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rspm_pkg::RSPM_ST_CAPTURE: begin
                if (mode_strap == rspm_pkg::IFACE_SPI_MASTER) begin
                    state_next = rspm_pkg::RSPM_ST_AUTOCFG;
                end else begin
                    state_next = rspm_pkg::RSPM_ST_RUN;
                end
            end
            rspm_pkg::RSPM_ST_AUTOCFG: begin
                // a done pulse in any other state is ignored
                if (autocfg_done) begin
                    state_next = rspm_pkg::RSPM_ST_RUN; // see RULE_10
                end
            end
            rspm_pkg::RSPM_ST_RUN: begin
                // only a reset leaves this state
                state_next = rspm_pkg::RSPM_ST_RUN; // see RULE_13
            end
            default: begin
                state_next = rspm_pkg::RSPM_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin // see RULE_11
            state_reg <= rspm_pkg::RSPM_ST_CAPTURE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // straps: loaded once in the capture state, frozen until the next reset
    always_comb begin
        acs_next = acs_reg;
        ifm_next = ifm_reg;
        ftest_next = ftest_reg;
        if (capture_now) begin
            acs_next = gpio_pin_in[2:0]; // see RULE_12
            ftest_next = gpio_pin_in[3]; // see RULE_04
            ifm_next = mode_strap; // see RULE_07
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin // see RULE_11
            acs_reg <= rspm_pkg::AUTO_CFG_RST;
            ifm_reg <= rspm_pkg::IFACE_RST;
            ftest_reg <= rspm_pkg::FTEST_RST;
        end else if (clk_en) begin
            acs_reg <= acs_next;
            ifm_reg <= ifm_next;
            ftest_reg <= ftest_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // chip-select ownership: taken at capture in master mode, handed back
    // for good on the done pulse
    always_comb begin
        cs_drive_next = cs_drive_reg;
        cs_val_next = !autocfg_busy; // see RULE_09
        if (capture_now) begin
            cs_drive_next = (mode_strap == rspm_pkg::IFACE_SPI_MASTER); // see RULE_09
        end else if (state_reg != rspm_pkg::RSPM_ST_AUTOCFG) begin
            cs_drive_next = 1'b0;
        end else if (autocfg_done) begin
            cs_drive_next = 1'b0; // see RULE_10
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_drive_reg <= rspm_pkg::CS_DRIVE_RST;
            cs_val_reg <= rspm_pkg::CS_VAL_RST;
        end else if (clk_en) begin
            cs_drive_reg <= cs_drive_next;
            cs_val_reg <= cs_val_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status: latched bit records a high seen since the last clear
    always_comb begin
        rt_next = gpio_pin_in; // see RULE_03
        lat_next = lat_reg;
        if (latch_clear) begin
            lat_next = rspm_pkg::GPIO_LATCH_RST;
        end
        // a pin high in the clear cycle stays latched: the set wins
        lat_next = lat_next | gpio_pin_in; // see RULE_03
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rt_reg <= rspm_pkg::GPIO_SYNC_RST;
            lat_reg <= rspm_pkg::GPIO_LATCH_RST;
        end else if (clk_en) begin
            rt_reg <= rt_next;
            lat_reg <= lat_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers: value and enable both come from flip-flops, so a config
    // change never puts a stale value on a pad for one cycle
    genvar gi;
    generate
        for (gi = 0; gi < rspm_pkg::NUM_GPIO; gi++) begin : g_pin
            // a pin stays an input while straps are sampled, never overdriving one
            assign drv_val_next[gi] = pin_cfg[gi][rspm_pkg::CFG_VAL_BIT]; // see RULE_02
            assign drv_oe_n_next[gi] = (state_next == rspm_pkg::RSPM_ST_CAPTURE)
                || !pin_cfg[gi][rspm_pkg::CFG_OE_BIT]; // see RULE_01
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin // see RULE_11
            drv_val_reg <= rspm_pkg::GPIO_VAL_RST;
            drv_oe_n_reg <= rspm_pkg::GPIO_OE_N_RST;
        end else if (clk_en) begin
            drv_val_reg <= drv_val_next;
            drv_oe_n_reg <= drv_oe_n_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // the chip select is driven only while auto-configuration owns it
    assign spi_select_n_out = cs_val_reg; // see RULE_09
    assign spi_select_n_oe_n = !cs_drive_reg; // see RULE_10

    // as slave the external master owns the pin; elsewhere the pin reads idle
    always_comb begin
        if ((ifm_reg == rspm_pkg::IFACE_SPI_SLAVE)
            && (state_reg == rspm_pkg::RSPM_ST_RUN)) begin
            spi_select_n_slave = spi_select_n_in; // see RULE_08
        end else begin
            spi_select_n_slave = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign gpio_pin_out = drv_val_reg; // see RULE_02
    assign gpio_pin_oe_n = drv_oe_n_reg; // see RULE_01
    assign auto_config_select = acs_reg; // see RULE_12
    assign iface_mode = ifm_reg; // see RULE_07
    assign factory_test_mode = ftest_reg; // see RULE_05
    assign straps_valid = !capture_now;
    assign autocfg_active = cs_drive_reg;
    assign gpio_status_rt = rt_reg;
    assign gpio_status_latched = lat_reg;

endmodule

/* File: tb/rspm_far_side.sv */
`timescale 1ns/1ns
module rspm_far_side (
    input wire logic host_n, spi_select_n_out, spi_select_n_oe_n,
    output logic spi_select_n_in
);
    // host holds the line whenever the device lets go, so it never floats
    assign spi_select_n_in = spi_select_n_oe_n ? host_n : spi_select_n_out;
endmodule

/* File: tb/rspm_strap_mux_assertions.sv */
`timescale 1ns/1ns
module rspm_strap_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic spi_select_n_in,
    input wire logic spi_select_n_oe_n,
    input wire logic spi_select_n_slave,
    input wire logic iface_mode_bit1,
    input wire logic autocfg_done,
    input wire logic factory_test_mode,
    input wire logic straps_valid,
    input wire logic [3:0] gpio_pin_in,
    input wire logic [3:0] gpio_status_rt,
    input wire logic [3:0] gpio_status_latched,
    input wire logic [2:0] auto_config_select,
    input wire logic [1:0] iface_mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    pin_hold_a: assert property ($past(straps_valid) |->
        $stable({factory_test_mode, auto_config_select})) else $error("pins");
    mode_hold_a: assert property ($past(straps_valid) |->
        $stable(iface_mode)) else $error("mode");
    pin_capture_a: assert property ($rose(straps_valid) |->
        {factory_test_mode, auto_config_select} == $past(gpio_pin_in)) else $error("pin");
    mode_capture_a: assert property ($rose(straps_valid) |->
        iface_mode == {$past(iface_mode_bit1), $past(spi_select_n_in)}) else $error("if");
    cs_idle_a: assert property (!straps_valid |->
        spi_select_n_oe_n) else $error("idle");
    cs_own_a: assert property ($rose(straps_valid) |->
        !spi_select_n_oe_n == (iface_mode == rspm_pkg::IFACE_SPI_MASTER)) else $error("own");
    master_only_a: assert property (!spi_select_n_oe_n |->
        iface_mode == rspm_pkg::IFACE_SPI_MASTER) else $error("drv");
    cs_free_a: assert property (
        straps_valid && (spi_select_n_oe_n || (autocfg_done && clk_en))
        |=> spi_select_n_oe_n) else $error("free");
    rt_follow_a: assert property (clk_en |=>
        gpio_status_rt == $past(gpio_pin_in)) else $error("rt");
    latch_set_a: assert property (clk_en |=>
        (gpio_status_latched & $past(gpio_pin_in)) == $past(gpio_pin_in)) else $error("lat");
    slave_pass_a: assert property (straps_valid && (iface_mode == rspm_pkg::IFACE_SPI_SLAVE)
        |-> spi_select_n_slave == spi_select_n_in) else $error("slave");
    slave_idle_a: assert property ((iface_mode != rspm_pkg::IFACE_SPI_SLAVE) |->
        spi_select_n_slave) else $error("slave idle");
endmodule
bind rspm_strap_mux rspm_strap_chk chk_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .spi_select_n_in(spi_select_n_in),
    .spi_select_n_oe_n(spi_select_n_oe_n),
    .spi_select_n_slave(spi_select_n_slave),
    .iface_mode_bit1(iface_mode_bit1),
    .autocfg_done(autocfg_done),
    .factory_test_mode(factory_test_mode),
    .straps_valid(straps_valid),
    .gpio_pin_in(gpio_pin_in),
    .gpio_status_rt(gpio_status_rt),
    .gpio_status_latched(gpio_status_latched),
    .auto_config_select(auto_config_select),
    .iface_mode(iface_mode)
);

/* File: tb/rspm_strap_mux_tb.sv */
`timescale 1ns/1ns
module rspm_strap_mux_tb;
    logic core_clk = 0, rst_n = 0, clk_en = 1, iface_mode_bit1 = 0, host_n = 0;
    logic autocfg_busy = 1, autocfg_done = 0, latch_clear = 0, spi_select_n_in, spi_select_n_out;
    logic spi_select_n_oe_n, factory_test_mode, straps_valid, autocfg_active, spi_select_n_slave;
    logic [3:0] ext = 0, gpio_config_reg_1 = 0, gpio_pin_in, gpio_pin_out, gpio_pin_oe_n;
    logic [3:0] gpio_status_rt, gpio_status_latched;
    logic [2:0] auto_config_select;
    logic [1:0] gpio_pin_2_config = 0, gpio_pin_3_config = 0, iface_mode;
    int err_total = 0, check_count = 0;
    initial forever #5 core_clk = ~core_clk;
    rspm_far_side far_u (.*);
    rspm_strap_mux dut_u (.*);
    assign gpio_pin_in = gpio_pin_oe_n & ext | ~gpio_pin_oe_n & gpio_pin_out;
    task chk(input logic [7:0] g, e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t %0h %0h", $time, g, e);
        end
    endtask
    task tk(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task restrap(logic [3:0] pins, logic [1:0] md);
        tk(1);
        rst_n <= 0;
        ext <= pins;
        {iface_mode_bit1, host_n} <= md;
        tk(10);
        rst_n <= 1;
        tk(2);
        #1 chk({spi_select_n_in, iface_mode, factory_test_mode, auto_config_select},
            {md[0], md, pins});
    endtask
    task t_master;
        restrap(4'h1, rspm_pkg::IFACE_SPI_MASTER);
        tk(1);
        autocfg_busy <= 0;
        tk(2);
        #1 chk({autocfg_active, spi_select_n_oe_n, spi_select_n_in}, 8'h5);
        tk(1);
        autocfg_busy <= 1;
        autocfg_done <= 1;
        tk(1);
        autocfg_done <= 0;
        #1 chk({autocfg_active, spi_select_n_oe_n, spi_select_n_in}, 8'h2);
    endtask
    task t_gpio;
        tk(1);
        {gpio_config_reg_1, gpio_pin_2_config, gpio_pin_3_config, ext} <= 12'hB74;
        tk(2);
        #1 chk({gpio_pin_oe_n, gpio_pin_out}, 8'h4D);
        chk({gpio_status_rt, gpio_status_latched}, 8'hDD);
        tk(1);
        {gpio_config_reg_1, gpio_pin_2_config, gpio_pin_3_config, ext} <= 12'h0;
        tk(2);
        #1 chk({gpio_status_rt, gpio_status_latched}, 8'h0D);
    endtask
    task t_misc;
        restrap(4'h0, rspm_pkg::IFACE_SPI_SLAVE);
        tk(1);
        host_n <= 0;
        ext <= 4'h6;
        tk(2);
        #1 chk({spi_select_n_slave, gpio_status_latched}, 8'h06);
        tk(1);
        latch_clear <= 1;
        ext <= 4'h2;
        tk(1);
        latch_clear <= 0;
        clk_en <= 0;
        ext <= 4'h9;
        tk(3);
        #1 chk({gpio_status_rt, gpio_status_latched}, 8'h22);
        tk(1);
        clk_en <= 1;
        autocfg_done <= 1;
        tk(1);
        autocfg_done <= 0;
        tk(1);
        #1 chk({spi_select_n_oe_n, iface_mode, gpio_status_rt}, 8'h59);
    endtask
    task give_verdict;
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        for (int m = 0; m < 4; m++) restrap(4'(m * 5 + 3), 2'(m));
        t_master;
        t_gpio;
        t_misc;
        give_verdict;
    end
endmodule
